/* File: dbu_pkg.sv */
// constants, types and helpers for the debug breakpoint unit
// assumes a 32-bit classic wishbone register path and core event strobes
package dbu_pkg;

    localparam int          NUM_SLOTS     = 4;
    localparam int          ADR_W         = 8;

    // register byte offsets
    localparam logic [7:0]  OFS_BP0       = 8'h00;
    localparam logic [7:0]  OFS_BP1       = 8'h04;
    localparam logic [7:0]  OFS_BP2       = 8'h08;
    localparam logic [7:0]  OFS_BP3       = 8'h0c;
    localparam logic [7:0]  OFS_STATUS    = 8'h10;
    localparam logic [7:0]  OFS_CTRL      = 8'h14;

    // debug_control fields
    localparam int          CTL_LE        = 8;
    localparam int          CTL_GE        = 9;
    localparam int          CTL_GD        = 13;
    localparam int          CTL_SLOT_LSB  = 16;
    localparam int          CTL_SLOT_W    = 4;
    localparam logic [31:0] CTRL_RESET    = 32'h0000_0000;
    localparam logic [31:0] CTRL_WMASK    = 32'hffff_23ff;
    localparam logic [31:0] CTRL_LOCAL    = 32'h0000_0155;
    localparam logic [31:0] CTRL_GD_MASK  = 32'h0000_2000;

    // debug_status fields
    localparam int          ST_BD         = 13;
    localparam int          ST_BS         = 14;
    localparam int          ST_BT         = 15;
    localparam logic [31:0] STATUS_RESET  = 32'h0000_0000;
    localparam logic [31:0] STATUS_WMASK  = 32'h0000_e00f;
    localparam logic [31:0] ADDR_RESET    = 32'h0000_0000;

    // slot_access_type and slot_match_size encodings
    localparam logic [1:0]  TYPE_FETCH    = 2'h0;
    localparam logic [1:0]  TYPE_WRITE    = 2'h1;
    localparam logic [1:0]  TYPE_RDWR     = 2'h3;
    localparam logic [1:0]  LEN_1         = 2'h0;
    localparam logic [1:0]  LEN_2         = 2'h1;
    localparam logic [1:0]  LEN_4         = 2'h3;

    typedef enum logic {TT_IDLE, TT_ARMED} dbu_tt_state_t;

    // bytes of a dword covered by a breakpoint field
    function automatic logic [3:0] dbu_field_be(input logic [1:0] len, input logic [1:0] lo);
        logic [3:0] be;
        be = 4'h0;
        unique case (len)
            LEN_1:   be = 4'h1 << lo;
            LEN_2:   be = lo[1] ? 4'hc : 4'h3;
            LEN_4:   be = 4'hf;
            default: be = 4'h0;
        endcase
        return be;
    endfunction

    // byte-lane write merge
    function automatic logic [31:0] dbu_merge(input logic [31:0] old, input logic [31:0] wd,
                                              input logic [3:0] sel);
        logic [31:0] m;
        m = old;
        for (int b = 0; b < 4; b++) begin
            if (sel[b]) begin
                m[8*b +: 8] = wd[8*b +: 8];
            end
        end
        return m;
    endfunction

endpackage

/* File: dbu_slot_match.sv */
// one breakpoint slot comparator: fetch and data match
// assumes a data access lies within one dword, given by byte enables
module dbu_slot_match
    import dbu_pkg::*;
(
    input  wire logic [31:0] bp_addr,
    input  wire logic [1:0]  bp_len,
    input  wire logic [1:0]  bp_type,
    input  wire logic        fetch_valid,
    input  wire logic [31:0] fetch_addr,
    input  wire logic        data_valid,
    input  wire logic [31:0] data_addr,
    input  wire logic [3:0]  data_be,
    input  wire logic        data_write,
    output logic             fetch_match,
    output logic             data_match
);
    wire logic       is_fetch_slot;
    wire logic       type_ok;
    wire logic [3:0] field_be;

    assign is_fetch_slot = (bp_type == TYPE_FETCH) && (bp_len == LEN_1); // [RULE_01]
    assign fetch_match   = fetch_valid && is_fetch_slot && (fetch_addr == bp_addr); // [RULE_02]
    assign type_ok       = (bp_type == TYPE_RDWR) || ((bp_type == TYPE_WRITE) && data_write); // [RULE_23]
    assign field_be      = dbu_field_be(bp_len, bp_addr[1:0]); // [RULE_22]
    assign data_match    = data_valid && type_ok && (data_addr[31:2] == bp_addr[31:2])
                           && ((data_be & field_be) != 4'h0); // [RULE_23]
endmodule

/* File: dbu_breakpoint_unit.sv */
// debug breakpoint unit: four linear-address breakpoints, debug status/control
// assumes core event inputs are one-cycle strobes synchronous to clock
// Overview of operation
// [RULE_01] a slot is a fetch breakpoint only with type 00 and size 00
// [RULE_02] enabled fetch breakpoint at instruction start byte raises a fault
// [RULE_03] debug registers accessible only in real mode or privilege 0
// [RULE_04] with access guard set, any debug register access faults instead
// [RULE_05] access guard clears automatically when the handler is entered
// [RULE_06] exact-match bits stall next instruction until data transfers finish
// [RULE_07] without exact match, data breakpoints may report late or never
// [RULE_08] task switch clears the local exact-match bit
// [RULE_09] global exact-match bit survives task switches
// [RULE_10] fetch breakpoints are always reported exactly
// [RULE_11] slot enabled by global or local enable; hit invokes handler
// [RULE_12] task switch clears all local enables, keeps global enables
// [RULE_13] hardware only sets status flags, software clears them
// [RULE_14] four hit flags, one per slot, set on slot condition
// [RULE_15] fetch hits deliver a fault, data hits a trap after transfer
// [RULE_16] on any enabled hit, flag every matching slot, enabled or not
// [RULE_17] guarded access sets the guarded-access flag
// [RULE_18] single-step trap sets the single-step flag
// [RULE_19] task switch with trap bit: trap before first instruction, flag set
// [RULE_20] resume flag suppresses fetch breakpoint at the return address
// [RULE_21] all slots disabled after reset
// [RULE_22] size 00 one byte, 01 two bytes, 11 four bytes, 10 undefined
// [RULE_23] type 00 fetch, 01 writes, 11 reads or writes; overlap matches
//
// Implementation choices: the placing of the registers and register access over Wishbone.
module dbu_breakpoint_unit
    import dbu_pkg::*;
(
    input  wire logic                     clock,
    input  wire logic                     rst_n,
    input  wire logic                     wb_cyc_i,
    input  wire logic                     wb_stb_i,
    input  wire logic                     wb_we_i,
    input  wire logic [dbu_pkg::ADR_W-1:0] wb_adr_i,
    input  wire logic [31:0]              wb_dat_i,
    input  wire logic [3:0]               wb_sel_i,
    output logic [31:0]                   wb_dat_o,
    output logic                          wb_ack_o,
    input  wire logic                     fetch_valid,
    input  wire logic [31:0]              fetch_addr,
    input  wire logic                     data_valid,
    input  wire logic [31:0]              data_addr,
    input  wire logic [3:0]               data_be,
    input  wire logic                     data_write,
    input  wire logic                     data_busy,
    input  wire logic                     real_mode,
    input  wire logic [1:0]               cpl,
    input  wire logic                     dreg_access,
    input  wire logic                     trap_step_flag,
    input  wire logic                     insn_retire,
    input  wire logic                     resume_suppress_flag,
    input  wire logic                     task_switch,
    input  wire logic                     tss_trap_bit,
    input  wire logic                     handler_enter,
    output logic                          dreg_access_ok,
    output logic                          hold_next,
    output logic                          dbg_fault,
    output logic                          dbg_trap,
    output logic [31:0]                   debug_control,
    output logic [31:0]                   debug_status
);
    import dbu_pkg::*;

    logic [31:0]        bp_addr_reg [NUM_SLOTS];
    logic [31:0]        ctrl_reg;
    logic [31:0]        ctrl_next;
    logic [31:0]        status_reg;
    logic [31:0]        status_next;
    logic               ack_reg;
    logic [31:0]        rdata_reg;
    logic               fault_reg;
    logic               trap_reg;
    dbu_tt_state_t      tt_reg;
    dbu_tt_state_t      tt_next;

    wire logic [NUM_SLOTS-1:0] fetch_match;
    wire logic [NUM_SLOTS-1:0] data_match;
    wire logic [NUM_SLOTS-1:0] slot_en;
    wire logic [NUM_SLOTS-1:0] slot_hit;
    wire logic [NUM_SLOTS-1:0] fetch_live;
    wire logic          bus_req;
    wire logic          wr_fire;
    wire logic          rd_fire;
    wire logic          ctrl_wr;
    wire logic          status_wr;
    wire logic          fetch_take;
    wire logic          data_take;
    wire logic          any_take;
    wire logic          guard_fault;
    wire logic          exact_on;
    wire logic          tt_fire;
    wire logic [31:0]   ctrl_merged;
    wire logic [31:0]   ctrl_clear;
    wire logic [31:0]   status_merged;
    wire logic [31:0]   status_set;
    wire logic [31:0]   rd_mux;

    // slot comparators
    genvar i;
    generate
        for (i = 0; i < NUM_SLOTS; i++) begin : g_slot
            dbu_slot_match u_match (
                .bp_addr     (bp_addr_reg[i]),
                .bp_len      (ctrl_reg[CTL_SLOT_LSB + CTL_SLOT_W*i + 2 +: 2]),
                .bp_type     (ctrl_reg[CTL_SLOT_LSB + CTL_SLOT_W*i +: 2]),
                .fetch_valid (fetch_valid),
                .fetch_addr  (fetch_addr),
                .data_valid  (data_valid),
                .data_addr   (data_addr),
                .data_be     (data_be),
                .data_write  (data_write),
                .fetch_match (fetch_match[i]),
                .data_match  (data_match[i])
            );
            assign slot_en[i] = ctrl_reg[2*i] | ctrl_reg[2*i+1]; // [RULE_11]

            always_ff @(posedge clock or negedge rst_n) begin
                if (!rst_n) begin
                    bp_addr_reg[i] <= ADDR_RESET;
                end else if (wr_fire && wb_adr_i == OFS_BP0 + 8'(4*i)) begin
                    bp_addr_reg[i] <= dbu_merge(bp_addr_reg[i], wb_dat_i, wb_sel_i);
                end
            end
        end
    endgenerate

    // match qualification
    assign fetch_live  = fetch_match & ~{NUM_SLOTS{resume_suppress_flag}}; // [RULE_20]
    assign fetch_take  = |(fetch_live & slot_en); // [RULE_02] [RULE_10]
    assign data_take   = |(data_match & slot_en); // [RULE_11] [RULE_07]
    assign any_take    = fetch_take | data_take;
    assign slot_hit    = any_take ? (fetch_live | data_match) : '0; // [RULE_14] [RULE_16]

    // debug register access guard
    assign guard_fault    = dreg_access && ctrl_reg[CTL_GD]; // [RULE_04]
    assign dreg_access_ok = dreg_access && !ctrl_reg[CTL_GD]
                            && (real_mode || cpl == 2'h0); // [RULE_03]

    // exact data reporting
    assign exact_on  = ctrl_reg[CTL_GE] | ctrl_reg[CTL_LE];
    assign hold_next = exact_on && data_busy; // [RULE_06]

    // task-switch trap waits for the new task's first instruction
    assign tt_fire = (tt_reg == TT_ARMED) && fetch_valid; // [RULE_19]
    always_comb begin
        tt_next = tt_reg;
        unique case (tt_reg)
            TT_IDLE:  if (task_switch && tss_trap_bit) begin
                tt_next = TT_ARMED;
            end
            TT_ARMED: if (fetch_valid) begin
                tt_next = TT_IDLE;
            end
        endcase
    end

    // wishbone decode
    assign bus_req   = wb_cyc_i && wb_stb_i && !ack_reg;
    assign wr_fire   = bus_req && wb_we_i;
    assign rd_fire   = bus_req && !wb_we_i;
    assign ctrl_wr   = wr_fire && wb_adr_i == OFS_CTRL;
    assign status_wr = wr_fire && wb_adr_i == OFS_STATUS;
    assign rd_mux    = (wb_adr_i == OFS_BP0)    ? bp_addr_reg[0] :
                       (wb_adr_i == OFS_BP1)    ? bp_addr_reg[1] :
                       (wb_adr_i == OFS_BP2)    ? bp_addr_reg[2] :
                       (wb_adr_i == OFS_BP3)    ? bp_addr_reg[3] :
                       (wb_adr_i == OFS_STATUS) ? status_reg :
                       (wb_adr_i == OFS_CTRL)   ? ctrl_reg : 32'h0000_0000;

    // control register next value
    assign ctrl_merged = ctrl_wr ? (dbu_merge(ctrl_reg, wb_dat_i, wb_sel_i) & CTRL_WMASK) : ctrl_reg;
    assign ctrl_clear  = (handler_enter ? CTRL_GD_MASK : 32'h0000_0000)  // [RULE_05]
                       | (task_switch ? CTRL_LOCAL : 32'h0000_0000);     // [RULE_08] [RULE_09] [RULE_12]
    assign ctrl_next   = ctrl_merged & ~ctrl_clear;

    // status register: hardware sets win over a software write
    assign status_merged = status_wr ? (dbu_merge(status_reg, wb_dat_i, wb_sel_i) & STATUS_WMASK)
                                     : status_reg; // [RULE_13]
    assign status_set    = {16'h0000, tt_fire, trap_step_flag && insn_retire, guard_fault,
                            9'h000, slot_hit}; // [RULE_14] [RULE_17] [RULE_18] [RULE_19]
    assign status_next   = status_merged | status_set; // [RULE_13]

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            ctrl_reg   <= CTRL_RESET; // [RULE_21]
            status_reg <= STATUS_RESET;
            tt_reg     <= TT_IDLE;
        end else begin
            ctrl_reg   <= ctrl_next;
            status_reg <= status_next;
            tt_reg     <= tt_next;
        end
    end

    // exception strobes
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            fault_reg <= 1'b0;
            trap_reg  <= 1'b0;
        end else begin
            fault_reg <= fetch_take || guard_fault; // [RULE_15] [RULE_04]
            trap_reg  <= data_take || (trap_step_flag && insn_retire) || tt_fire; // [RULE_15]
        end
    end

    // bus answer
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            ack_reg   <= 1'b0;
            rdata_reg <= 32'h0000_0000;
        end else begin
            ack_reg   <= bus_req;
            if (rd_fire) begin
                rdata_reg <= rd_mux;
            end
        end
    end

    assign wb_ack_o      = ack_reg;
    assign wb_dat_o      = rdata_reg;
    assign dbg_fault     = fault_reg;
    assign dbg_trap      = trap_reg;
    assign debug_control = ctrl_reg;
    assign debug_status  = status_reg;

    // checks
    sequence s_tt_arm;
        task_switch && tss_trap_bit && tt_reg == TT_IDLE;
    endsequence

    sequence s_first_insn;
        !fetch_valid ##1 fetch_valid;
    endsequence

    a_fetch_fault: assert property (@(posedge clock) disable iff (!rst_n) // [RULE_02]
        (fetch_valid && !resume_suppress_flag && |(fetch_match & slot_en)) |=> dbg_fault)
        else $error("enabled fetch breakpoint gave no fault");

    a_resume_block: assert property (@(posedge clock) disable iff (!rst_n) // [RULE_20]
        (resume_suppress_flag && !dreg_access && !(|(fetch_match & ~slot_en))
         && !data_take) |=> !dbg_fault)
        else $error("fault taken while resume flag set");

    a_guard_fault: assert property (@(posedge clock) disable iff (!rst_n) // [RULE_04]
        (dreg_access && ctrl_reg[CTL_GD]) |-> !dreg_access_ok ##1 (dbg_fault && status_reg[ST_BD]))
        else $error("guarded access did not fault");

    a_priv_gate: assert property (@(posedge clock) disable iff (!rst_n) // [RULE_03]
        (dreg_access && !real_mode && cpl != 2'h0) |-> !dreg_access_ok)
        else $error("debug register access allowed above privilege 0");

    a_guard_clear: assert property (@(posedge clock) disable iff (!rst_n) // [RULE_05]
        handler_enter |=> !ctrl_reg[CTL_GD])
        else $error("access guard survived handler entry");

    a_exact_hold: assert property (@(posedge clock) disable iff (!rst_n) // [RULE_06]
        data_busy |-> (hold_next == (ctrl_reg[CTL_GE] || ctrl_reg[CTL_LE])))
        else $error("exact match stall wrong");

    a_task_local: assert property (@(posedge clock) disable iff (!rst_n) // [RULE_12]
        (task_switch && !ctrl_wr) |=> ((ctrl_reg & CTRL_LOCAL) == 32'h0
            && (ctrl_reg & ~CTRL_LOCAL & ~CTRL_GD_MASK) == ($past(ctrl_reg) & ~CTRL_LOCAL & ~CTRL_GD_MASK)))
        else $error("task switch mishandled enables");

    a_status_sticky: assert property (@(posedge clock) disable iff (!rst_n) // [RULE_13]
        !status_wr |=> ((status_reg & $past(status_reg)) == $past(status_reg)))
        else $error("status flag cleared by hardware");

    a_hit_all: assert property (@(posedge clock) disable iff (!rst_n) // [RULE_16]
        any_take |=> ((status_reg[NUM_SLOTS-1:0] & $past(fetch_live | data_match))
                      == $past(fetch_live | data_match)))
        else $error("matching slot flag not set");

    a_data_trap: assert property (@(posedge clock) disable iff (!rst_n) // [RULE_15]
        data_take |=> dbg_trap)
        else $error("data breakpoint gave no trap");

    a_task_trap: assert property (@(posedge clock) disable iff (!rst_n) // [RULE_19]
        s_tt_arm ##1 s_first_insn |=> (dbg_trap && status_reg[ST_BT]))
        else $error("task switch trap missing");

    a_step_flag: assert property (@(posedge clock) disable iff (!rst_n) // [RULE_18]
        (trap_step_flag && insn_retire) |=> (dbg_trap && status_reg[ST_BS]))
        else $error("single step flag not set");

    a_ack_pulse: assert property (@(posedge clock) disable iff (!rst_n)
        wb_ack_o |=> !wb_ack_o)
        else $error("ack held longer than one cycle");

endmodule

/* File: dbu_core_model.sv */
// core-side model: drives fetch, data and event strobes of the unit
// assumes the bench calls its tasks and sets its level outputs off-edge
module dbu_core_model (
    input  wire logic        clock,
    output logic             fetch_valid,
    output logic [31:0]      fetch_addr,
    output logic             data_valid,
    output logic [31:0]      data_addr,
    output logic [3:0]       data_be,
    output logic             data_write,
    output logic             data_busy,
    output logic             real_mode,
    output logic [1:0]       cpl,
    output logic             dreg_access,
    output logic             trap_step_flag,
    output logic             insn_retire,
    output logic             resume_suppress_flag,
    output logic             task_switch,
    output logic             tss_trap_bit,
    output logic             handler_enter
);
    timeunit 1ns;
    timeprecision 1ns;

    initial begin
        {fetch_valid, data_valid, data_write, data_busy, real_mode, dreg_access} = '0;
        {trap_step_flag, insn_retire, resume_suppress_flag, task_switch} = '0;
        {tss_trap_bit, handler_enter, cpl, data_be} = '0;
        fetch_addr = 32'h0;
        data_addr = 32'h0;
    end

    // raise one strobe: 0 fetch, 1 data, 2 register access, 3 retire, 4 switch, 5 handler
    task automatic ev_on(input int k, input logic [31:0] a = 32'h0, input logic [3:0] be = 4'h0,
                         input logic w = 1'b0);
        @(posedge clock);
        case (k)
            0: begin
                fetch_valid <= 1'b1;
                fetch_addr <= a;
            end
            1: begin
                data_valid <= 1'b1;
                data_addr <= a;
                data_be <= be;
                data_write <= w;
            end
            2: dreg_access <= 1'b1;
            3: insn_retire <= 1'b1;
            4: task_switch <= 1'b1;
            default: handler_enter <= 1'b1;
        endcase
    endtask

    // drop strobes; stale qualifiers turn to their inverse
    task automatic ev_off;
        @(posedge clock);
        {fetch_valid, data_valid, dreg_access, insn_retire, task_switch, handler_enter} <= '0;
        fetch_addr <= ~fetch_addr;
        data_addr <= ~data_addr;
        data_be <= ~data_be;
        data_write <= ~data_write;
    endtask

    task automatic ev(input int k, input logic [31:0] a = 32'h0, input logic [3:0] be = 4'h0,
                      input logic w = 1'b0);
        ev_on(k, a, be, w);
        ev_off();
    endtask
endmodule

/* File: dbu_breakpoint_unit_bench.sv */
// self-checking bench for the debug breakpoint unit
// assumes dbu_pkg, the design and dbu_core_model are compiled first
`define CHK(a, e) begin compares++; if ((a) !== (e)) begin n_mismatch++; \
    $display("[ERR] t=%0t got=%h exp=%h", $time, a, e); end end
module dbu_breakpoint_unit_bench;
    import dbu_pkg::*;
    timeunit 1ns;
    timeprecision 1ns;
    logic        clock, rst_n, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
    logic [7:0]  wb_adr_i;
    logic [31:0] wb_dat_i, wb_dat_o, fetch_addr, data_addr, debug_control, debug_status, q;
    logic [3:0]  wb_sel_i, data_be;
    logic [1:0]  cpl;
    logic        fetch_valid, data_valid, data_write, data_busy, real_mode, dreg_access;
    logic        trap_step_flag, insn_retire, resume_suppress_flag, task_switch, tss_trap_bit;
    logic        handler_enter, dreg_access_ok, hold_next, dbg_fault, dbg_trap;
    int          n_mismatch = 0;
    int          compares = 0;

    dbu_core_model core (.clock, .fetch_valid, .fetch_addr, .data_valid, .data_addr, .data_be,
        .data_write, .data_busy, .real_mode, .cpl, .dreg_access, .trap_step_flag, .insn_retire,
        .resume_suppress_flag, .task_switch, .tss_trap_bit, .handler_enter);
    dbu_breakpoint_unit dut (.clock, .rst_n, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_dat_i,
        .wb_sel_i, .wb_dat_o, .wb_ack_o, .fetch_valid, .fetch_addr, .data_valid, .data_addr, .data_be,
        .data_write, .data_busy, .real_mode, .cpl, .dreg_access, .trap_step_flag, .insn_retire,
        .resume_suppress_flag, .task_switch, .tss_trap_bit, .handler_enter, .dreg_access_ok,
        .hold_next, .dbg_fault, .dbg_trap, .debug_control, .debug_status);

    task automatic give_verdict;
        $display("compares=%0d mismatches=%0d", compares, n_mismatch);
        if (n_mismatch == 0 && compares > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    // classic wishbone single cycle, held until ack is sampled
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d = 32'h0);
        @(posedge clock);
        {wb_cyc_i, wb_stb_i, wb_we_i, wb_sel_i} <= {2'b11, w, 4'hf};
        wb_adr_i <= a;
        wb_dat_i <= d;
        do begin
            @(posedge clock);
        end while (wb_ack_o !== 1'b1);
        q = wb_dat_o;
        {wb_cyc_i, wb_stb_i, wb_we_i} <= 3'b000;
    endtask

    task automatic rdchk(input logic [7:0] a, input logic [31:0] e);
        wb(1'b0, a);
        `CHK(q, e)
    endtask

    task automatic t_reset;
        rdchk(OFS_CTRL, CTRL_RESET);
        rdchk(OFS_STATUS, STATUS_RESET);
        wb(1'b1, 8'h40, 32'hffff_ffff);
        rdchk(8'h40, 32'h0);
        core.ev(0, ADDR_RESET);
        #1;
        `CHK(dbg_fault, 1'b0)
        $display("test reset done");
    endtask

    task automatic t_fetch;
        wb(1'b1, OFS_BP0, 32'h0000_1000);
        wb(1'b1, OFS_CTRL, 32'h0000_0002);
        core.ev(0, 32'h0000_1000);
        #1;
        `CHK({dbg_fault, dbg_trap}, 2'b10)
        rdchk(OFS_STATUS, 32'h1);
        wb(1'b1, OFS_STATUS, 32'h0);
        rdchk(OFS_STATUS, 32'h0);
        core.resume_suppress_flag <= 1'b1;
        core.ev(0, 32'h0000_1000);
        #1;
        `CHK(dbg_fault, 1'b0)
        core.resume_suppress_flag <= 1'b0;
        wb(1'b1, OFS_CTRL, 32'h0004_0002);
        core.ev(0, 32'h0000_1000);
        #1;
        `CHK(dbg_fault, 1'b0)
        $display("test fetch done");
    endtask

    task automatic t_data;
        wb(1'b1, OFS_BP1, 32'h0000_2005);
        wb(1'b1, OFS_BP2, 32'h0000_2004);
        wb(1'b1, OFS_CTRL, 32'h0f50_0104);
        core.ev(1, 32'h0000_2004, 4'h1, 1'b0);
        #1;
        `CHK(dbg_trap, 1'b0)
        rdchk(OFS_STATUS, 32'h0);
        core.ev(1, 32'h0000_2004, 4'h2, 1'b1);
        #1;
        `CHK({dbg_fault, dbg_trap}, 2'b01)
        rdchk(OFS_STATUS, 32'h6);
        #1;
        core.data_busy <= 1'b1;
        #1;
        `CHK(hold_next, 1'b1)
        core.data_busy <= 1'b0;
        $display("test data done");
    endtask

    task automatic t_task;
        wb(1'b1, OFS_STATUS, 32'h0);
        wb(1'b1, OFS_CTRL, 32'h0f50_0306);
        #1;
        core.tss_trap_bit <= 1'b1;
        core.ev(4);
        #1;
        core.tss_trap_bit <= 1'b0;
        `CHK(dbg_trap, 1'b0)
        core.ev(0, 32'h0000_3000);
        #1;
        `CHK(dbg_trap, 1'b1)
        rdchk(OFS_CTRL, 32'h0f50_0306 & ~CTRL_LOCAL);
        `CHK(debug_control, 32'h0f50_0306 & ~CTRL_LOCAL)
        rdchk(OFS_STATUS, 32'h8000);
        $display("test task done");
    endtask

    task automatic t_guard;
        wb(1'b1, OFS_STATUS, 32'h0);
        #1;
        {core.real_mode, core.cpl} <= 3'b111;
        core.ev_on(2);
        #1;
        `CHK(dreg_access_ok, 1'b1)
        core.real_mode <= 1'b0;
        #1;
        `CHK(dreg_access_ok, 1'b0)
        core.ev_off();
        wb(1'b1, OFS_CTRL, CTRL_GD_MASK);
        #1;
        {core.real_mode, core.cpl} <= 3'b100;
        core.ev_on(2);
        #1;
        `CHK(dreg_access_ok, 1'b0)
        core.ev_off();
        #1;
        `CHK(dbg_fault, 1'b1)
        rdchk(OFS_STATUS, 32'h2000);
        core.ev(5);
        rdchk(OFS_CTRL, 32'h0);
        $display("test guard done");
    endtask

    task automatic t_step;
        wb(1'b1, OFS_STATUS, 32'h0);
        #1;
        core.trap_step_flag <= 1'b1;
        core.ev(3);
        #1;
        core.trap_step_flag <= 1'b0;
        `CHK(dbg_trap, 1'b1)
        rdchk(OFS_STATUS, 32'h4000);
        `CHK(debug_status, 32'h4000)
        $display("test step done");
    endtask

    initial begin
        clock = 1'b0;
        forever #50 clock = ~clock;
    end

    initial begin
        rst_n = 1'b0;
        {wb_cyc_i, wb_stb_i, wb_we_i, wb_sel_i, wb_adr_i, wb_dat_i} = '0;
        repeat (6) @(posedge clock);
        rst_n <= 1'b1;
        t_reset();
        t_fetch();
        t_data();
        t_task();
        t_guard();
        t_step();
        give_verdict();
    end

    initial begin
        #400000;
        n_mismatch++;
        give_verdict();
    end
endmodule
